// ---- audio_port_pkg.sv ----
// =====================================================================
// Shared constants of the serial audio output port
// =====================================================================
package audio_port_pkg;
   // Sample rate bounds of the three speed ranges, kHz
   localparam int SINGLE_MIN_KHZ = 2;
   localparam int SINGLE_MAX_KHZ = 54;
   localparam int DOUBLE_MAX_KHZ = 108;
   localparam int QUAD_MAX_KHZ   = 216;

   // Speed range select encoding
   localparam logic [1:0] SPEED_SINGLE = 2'h0;
   localparam logic [1:0] SPEED_DOUBLE = 2'h1;
   localparam logic [1:0] SPEED_QUAD   = 2'h2;

   // Filter latency in output sample periods per speed range
   localparam int         LAT_W       = 5;
   localparam logic [4:0] LAT_SINGLE  = 5'h0c;
   localparam logic [4:0] LAT_DOUBLE  = 5'h09;
   localparam logic [4:0] LAT_QUAD    = 5'h05;

   // Frame layout: 64 bit clocks, two 32-bit slots, 24-bit samples
   localparam int SAMPLE_W       = 24;
   localparam int SLOT_W         = 32;
   localparam int PAD_W          = SLOT_W - SAMPLE_W;
   localparam int BITS_PER_FRAME = 64;
   localparam int CNT_W          = 6;
   localparam int SLOT_CNT_W     = 5;
   localparam logic [5:0] CNT_ONE   = 6'h01;
   localparam logic [4:0] SLOT_ZERO = 5'h00;
   localparam logic [4:0] SLOT_ONE  = 5'h01;

   // Overflow hold time is two to this power, minus one, sample periods
   localparam int OVF_EXP = 17;
   localparam int OVF_W   = OVF_EXP;
   localparam logic [16:0] OVF_ZERO = 17'h00000;
   localparam logic [16:0] OVF_ONE  = 17'h00001;
endpackage

// ---- sample_fifo.sv ----
`timescale 1ns/10ps
// =====================================================================
// Sample FIFO with registered read data
// =====================================================================
module sample_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic [AW+1:0]         level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic             push;
   logic             load;

   // Handshake terms; the output stage refills whenever it is free
   assign in_ready  = (count_reg < (AW+1)'(DEPTH));
   assign push      = in_valid && in_ready;
   assign load      = (count_reg != '0) && (!out_valid_reg || out_ready);
   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;
   assign level     = (AW+2)'(count_reg) + (AW+2)'(out_valid_reg);

   // Storage array, no reset needed
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (load) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
      end
   end

   // Registered read stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end else if (load) begin
         out_valid_reg <= 1'b1;
         out_data_reg  <= mem[rd_ptr_reg];
      end else if (out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule

// ---- audio_out_port.sv ----
`timescale 1ns/10ps
// What this block does
// RL1: Three speed ranges: single 2-54, double 54-108, quad 108-216 kHz.
// RL2: Output latency 12, 9 or 5 sample periods by speed range.
// RL3: Overflow indication held 2^17-1 sample periods after each overrange.
// RL4: Samples leave serially on data out, timed by bit and frame clocks.
// RL5: Master mode makes 64 bit clocks per frame clock period.
// RL6: Slave mode host picks the ratio; 64 per frame recommended.
// RL7: Data and master frame clock change on falling bit clock edge.
module audio_out_port #(
   parameter int FIFO_DEPTH      = 16,
   parameter int BCLK_HALF_DIV   = 20,
   parameter int OVF_HOLD_FRAMES = (1 << audio_port_pkg::OVF_EXP) - 1
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        master_mode,
   input  wire logic        format_i2s,
   input  wire logic [1:0]  speed_mode,
   input  wire logic        sample_valid,
   output logic             sample_ready,
   input  wire logic [23:0] sample_left,
   input  wire logic [23:0] sample_right,
   input  wire logic        overrange_event,
   output logic             overflow_indication,
   input  wire logic        bit_clk_i,
   output logic             bit_clk_o,
   output logic             bit_clk_oe,
   input  wire logic        frame_clock_i,
   output logic             frame_clock_o,
   output logic             frame_clock_oe,
   output logic             serial_data_out
);
   localparam int SW = audio_port_pkg::SAMPLE_W;
   localparam int FW = 2 * SW;
   localparam int AW = $clog2(FIFO_DEPTH);
   localparam int DW = $clog2(BCLK_HALF_DIV + 1);

   // =================================================================
   // Controller clock domain
   // =================================================================
   logic          fifo_valid;
   logic          fifo_take;
   logic [FW-1:0] fifo_data;
   logic [AW+1:0] fifo_level;
   logic [audio_port_pkg::LAT_W-1:0] lat_frames;
   logic          primed_reg;
   logic          req_reg;
   logic [FW-1:0] hold_reg;
   logic [1:0]    m_sync1_reg;
   logic [1:0]    m_sync2_reg;
   logic          frm_seen_reg;
   logic          frame_tick;
   logic          mbox_busy;
   logic [DW-1:0] div_cnt_reg;
   logic          bclk_reg;
   logic          bclk_oe_reg;
   logic [audio_port_pkg::OVF_W-1:0] ovf_cnt_reg;
   logic [audio_port_pkg::OVF_W-1:0] ovf_cnt_next;
   logic          ovf_flag_reg;
   logic          ack_reg;
   logic          frame_tog_reg;

   // Seventeen frames of slack between producer and link: sixteen stored, one in the read register
   sample_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (mclk),
      .rst_n     (rst_n),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   ({sample_left, sample_right}),
      .out_valid (fifo_valid),
      .out_ready (fifo_take),
      .out_data  (fifo_data),
      .level     (fifo_level)
   );

   // RL1: speed range latency
   always_comb begin
      if (speed_mode == audio_port_pkg::SPEED_QUAD) begin
         lat_frames = audio_port_pkg::LAT_QUAD;
      end else if (speed_mode == audio_port_pkg::SPEED_DOUBLE) begin
         lat_frames = audio_port_pkg::LAT_DOUBLE;
      end else begin
         lat_frames = audio_port_pkg::LAT_SINGLE;
      end
   end

   // RL2: prefill to latency
   // The link starts draining only once the chosen number of frames wait
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         primed_reg <= 1'b0;
      end else if (fifo_level >= (AW+2)'(lat_frames)) begin
         primed_reg <= 1'b1;
      end else if (fifo_level == '0) begin
         primed_reg <= 1'b0;
      end
   end

   // Toggle handshake; hold_reg stays still while a word is in flight
   assign mbox_busy = (req_reg != m_sync2_reg[1]);
   assign fifo_take = primed_reg && fifo_valid && !mbox_busy;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req_reg  <= 1'b0;
         hold_reg <= '0;
      end else if (fifo_take) begin
         req_reg  <= ~req_reg;
         hold_reg <= fifo_data;
      end
   end

   // Acknowledge and frame toggles come over from the link domain
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         m_sync1_reg  <= '0;
         m_sync2_reg  <= '0;
         frm_seen_reg <= 1'b0;
      end else begin
         m_sync1_reg  <= {ack_reg, frame_tog_reg};
         m_sync2_reg  <= m_sync1_reg;
         frm_seen_reg <= m_sync2_reg[0];
      end
   end
   assign frame_tick = m_sync2_reg[0] ^ frm_seen_reg;

   // RL3: overflow hold time-out
   // A new overrange reloads the count, so it wins over a frame tick
   always_comb begin
      ovf_cnt_next = ovf_cnt_reg;
      if (overrange_event) begin
         ovf_cnt_next = audio_port_pkg::OVF_W'(OVF_HOLD_FRAMES);
      end else if (frame_tick && (ovf_cnt_reg != audio_port_pkg::OVF_ZERO)) begin
         ovf_cnt_next = ovf_cnt_reg - audio_port_pkg::OVF_ONE;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_cnt_reg  <= '0;
         ovf_flag_reg <= 1'b0;
      end else begin
         ovf_cnt_reg  <= ovf_cnt_next;
         ovf_flag_reg <= (ovf_cnt_next != audio_port_pkg::OVF_ZERO);
      end
   end
   assign overflow_indication = ovf_flag_reg;

   // RL5: master bit clock divider
   // Rate is mclk / (2*BCLK_HALF_DIV); set it to 64 times the sample rate
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_reg <= '0;
         bclk_reg    <= 1'b0;
         bclk_oe_reg <= 1'b0;
      end else begin
         bclk_oe_reg <= master_mode;
         if (!master_mode) begin
            div_cnt_reg <= '0;
            bclk_reg    <= 1'b0;
         end else if (div_cnt_reg == DW'(BCLK_HALF_DIV - 1)) begin
            div_cnt_reg <= '0;
            bclk_reg    <= ~bclk_reg;
         end else begin
            div_cnt_reg <= div_cnt_reg + DW'(1);
         end
      end
   end
   assign bit_clk_o  = bclk_reg;
   assign bit_clk_oe = bclk_oe_reg;

   // =================================================================
   // Link clock domain (bit clock pin)
   // =================================================================
   logic [1:0]  l_rst_reg;
   logic        l_rst_n;
   logic [2:0]  l_sync1_reg;
   logic [2:0]  l_sync2_reg;
   logic        fc_rise_reg;
   logic        fc_last_reg;
   logic [audio_port_pkg::CNT_W-1:0] cnt_reg;
   logic [audio_port_pkg::CNT_W-1:0] cnt_inc;
   logic [audio_port_pkg::CNT_W-1:0] cnt_next;
   logic [SW-1:0] left_reg;
   logic [SW-1:0] right_reg;
   logic [SW-1:0] left_next;
   logic [SW-1:0] right_next;
   logic [audio_port_pkg::SLOT_W-1:0] sh_reg;
   logic [audio_port_pkg::SLOT_W-1:0] sh_next;
   logic        take_word;
   logic        left_load;
   logic        resync;
   logic        fc_side;
   logic        master_l;
   logic        i2s_l;
   logic        prev_bit_reg;
   logic        sdo_reg;
   logic        fco_reg;
   logic        fco_oe_reg;

   // Local reset release; assertion stays asynchronous
   always_ff @(negedge bit_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         l_rst_reg <= '0;
      end else begin
         l_rst_reg <= {l_rst_reg[0], 1'b1};
      end
   end
   assign l_rst_n = l_rst_reg[1];

   // Request toggle and mode levels into the link domain
   always_ff @(negedge bit_clk_i or negedge l_rst_n) begin
      if (!l_rst_n) begin
         l_sync1_reg <= '0;
         l_sync2_reg <= '0;
      end else begin
         l_sync1_reg <= {req_reg, master_mode, format_i2s};
         l_sync2_reg <= l_sync1_reg;
      end
   end
   assign master_l = l_sync2_reg[1];
   assign i2s_l    = l_sync2_reg[0];

   // RL7: host frame clock taken on rising edge
   always_ff @(posedge bit_clk_i or negedge l_rst_n) begin
      if (!l_rst_n) begin
         fc_rise_reg <= 1'b0;
      end else begin
         fc_rise_reg <= frame_clock_i;
      end
   end

   // RL6: slave locks to host frame edges
   // A mismatched edge forces bit one of the matching slot; any ratio is
   // followed, but only 64 per frame keeps every slot whole
   always_comb begin
      fc_side  = i2s_l ? fc_rise_reg : ~fc_rise_reg;
      cnt_inc  = cnt_reg + audio_port_pkg::CNT_ONE;
      cnt_next = cnt_inc;
      resync   = 1'b0;
      if (!master_l && (fc_rise_reg != fc_last_reg) && (cnt_inc != {fc_side, audio_port_pkg::SLOT_ONE})) begin
         cnt_next = {fc_side, audio_port_pkg::SLOT_ONE};
         resync   = 1'b1;
      end
   end

   // RL4: slot loading and shifting
   // An empty mailbox at frame start sends silence instead of stale data
   always_comb begin
      left_load  = !cnt_next[audio_port_pkg::CNT_W-1] &&
                   ((cnt_next[audio_port_pkg::SLOT_CNT_W-1:0] == audio_port_pkg::SLOT_ZERO) || resync);
      take_word  = left_load && (l_sync2_reg[2] != ack_reg);
      left_next  = left_reg;
      right_next = right_reg;
      if (take_word) begin
         left_next  = hold_reg[FW-1:SW];
         right_next = hold_reg[SW-1:0];
      end else if (left_load) begin
         left_next  = '0;
         right_next = '0;
      end
      sh_next = {sh_reg[audio_port_pkg::SLOT_W-2:0], 1'b0};
      if ((cnt_next[audio_port_pkg::SLOT_CNT_W-1:0] == audio_port_pkg::SLOT_ZERO) || resync) begin
         sh_next = {(cnt_next[audio_port_pkg::CNT_W-1] ? right_next : left_next),
                    {audio_port_pkg::PAD_W{1'b0}}};
         if (resync) begin
            sh_next = {sh_next[audio_port_pkg::SLOT_W-2:0], 1'b0};
         end
      end
   end

   // RL5: 64-count frame counter
   always_ff @(negedge bit_clk_i or negedge l_rst_n) begin
      if (!l_rst_n) begin
         cnt_reg       <= '1;
         fc_last_reg   <= 1'b0;
         left_reg      <= '0;
         right_reg     <= '0;
         sh_reg        <= '0;
         ack_reg       <= 1'b0;
         frame_tog_reg <= 1'b0;
      end else begin
         cnt_reg     <= cnt_next;
         fc_last_reg <= fc_rise_reg;
         left_reg    <= left_next;
         right_reg   <= right_next;
         sh_reg      <= sh_next;
         if (take_word) begin
            ack_reg <= ~ack_reg;
         end
         if (left_load) begin
            frame_tog_reg <= ~frame_tog_reg;
         end
      end
   end

   // RL7: outputs change on falling edge
   // I2S runs the data one bit behind the frame edge, left-justified does not
   always_ff @(negedge bit_clk_i or negedge l_rst_n) begin
      if (!l_rst_n) begin
         prev_bit_reg <= 1'b0;
         sdo_reg      <= 1'b0;
         fco_reg      <= 1'b0;
         fco_oe_reg   <= 1'b0;
      end else begin
         prev_bit_reg <= sh_next[audio_port_pkg::SLOT_W-1];
         sdo_reg      <= i2s_l ? prev_bit_reg : sh_next[audio_port_pkg::SLOT_W-1];
         fco_oe_reg   <= master_l;
         if (master_l) begin
            fco_reg <= i2s_l ? cnt_next[audio_port_pkg::CNT_W-1] : ~cnt_next[audio_port_pkg::CNT_W-1];
         end else begin
            fco_reg <= 1'b0;
         end
      end
   end
   assign serial_data_out = sdo_reg;
   assign frame_clock_o   = fco_reg;
   assign frame_clock_oe  = fco_oe_reg;
endmodule

// ---- audio_out_port_checker.sv ----
`timescale 1ns/10ps
// ====================
// Port checker
// ====================
module audio_out_port_checker #(
   parameter int BCLK_HALF_DIV   = 2,
   parameter int OVF_HOLD_FRAMES = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic master_mode,
   input wire logic format_i2s,
   input wire logic sample_ready,
   input wire logic overrange_event,
   input wire logic overflow_indication,
   input wire logic bit_clk_i,
   input wire logic bit_clk_o,
   input wire logic bit_clk_oe,
   input wire logic frame_clock_o,
   input wire logic frame_clock_oe,
   input wire logic serial_data_out
);
   localparam int FR  = 128 * BCLK_HALF_DIV;
   localparam int LIM = (OVF_HOLD_FRAMES + 1) * FR + 16;
   int   ev_cnt;
   int   hcnt;
   int   bcnt;
   logic bq;
   logic seen;
   logic fq;
   logic locked;
   logic armed;

   // Cycles since the last overrange; saturates so a long run never wraps
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         ev_cnt <= 0;
      else if (overrange_event)
         ev_cnt <= 0;
      else if (ev_cnt < LIM)
         ev_cnt <= ev_cnt + 1;
   end

   // Half period of the made bit clock; the first toggle only arms it
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bq   <= 1'b0;
         hcnt <= 0;
         seen <= 1'b0;
      end else begin
         bq   <= bit_clk_o;
         hcnt <= (bit_clk_o != bq) ? 0 : hcnt + 1;
         if (bit_clk_oe && bit_clk_o != bq)
            seen <= 1'b1;
      end
   end

   // Bit position within a slot, trusted from the second frame edge on:
   // the first edge after reset may fall in mid-slot
   always_ff @(posedge bit_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fq     <= 1'b0;
         bcnt   <= 0;
         armed  <= 1'b0;
         locked <= 1'b0;
      end else begin
         fq   <= frame_clock_o;
         bcnt <= (frame_clock_o != fq) ? 1 : bcnt + 1;
         if (frame_clock_oe && frame_clock_o != fq) begin
            armed  <= 1'b1;
            locked <= armed;
         end
      end
   end

   property p_ovf_set;
      @(posedge mclk) disable iff (!rst_n) overrange_event |=> overflow_indication [*2];
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not raised");
   property p_ovf_late;
      @(posedge mclk) disable iff (!rst_n)
      master_mode && $fell(overflow_indication) |-> ev_cnt >= (OVF_HOLD_FRAMES - 1) * FR;
   endproperty
   a_ovf_late: assert property (p_ovf_late) else $error("overflow flag released early");
   property p_ovf_early;
      @(posedge mclk) disable iff (!rst_n) master_mode && ev_cnt == LIM |-> !overflow_indication;
   endproperty
   a_ovf_early: assert property (p_ovf_early) else $error("overflow flag held too long");
   property p_reset_idle;
      @(posedge mclk) disable iff (!rst_n)
      $rose(rst_n) |-> !overflow_indication && !bit_clk_oe && !frame_clock_oe && !serial_data_out && sample_ready;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle out of reset");
   property p_slave_quiet;
      @(posedge mclk) disable iff (!rst_n)
      !master_mode && !$past(master_mode) |-> !bit_clk_oe && !bit_clk_o && !frame_clock_oe && !frame_clock_o;
   endproperty
   a_slave_quiet: assert property (p_slave_quiet) else $error("clock driven in slave mode");
   property p_bclk_half;
      @(posedge mclk) disable iff (!rst_n) bit_clk_oe && seen && bit_clk_o != bq |-> hcnt == BCLK_HALF_DIV - 1;
   endproperty
   a_bclk_half: assert property (p_bclk_half) else $error("bit clock half period wrong");
   property p_frame_len;
      @(posedge bit_clk_i) disable iff (!rst_n) frame_clock_oe && locked && frame_clock_o != fq |-> bcnt == 32;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame slot not 32 bit clocks");
   property p_pad_zero;
      @(posedge bit_clk_i) disable iff (!rst_n)
      frame_clock_oe && locked && !format_i2s && frame_clock_o == fq && bcnt >= 24 |-> !serial_data_out;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("pad bit not zero");
   property p_fall_edge;
      @(posedge mclk) disable iff (!rst_n)
      master_mode && bit_clk_oe && ($changed(serial_data_out) || $changed(frame_clock_o)) |-> $fell(bit_clk_i);
   endproperty
   a_fall_edge: assert property (p_fall_edge) else $error("data moved off falling edge");
endmodule

bind audio_out_port audio_out_port_checker #(
   .BCLK_HALF_DIV(BCLK_HALF_DIV), .OVF_HOLD_FRAMES(OVF_HOLD_FRAMES)
) u_checker (
   .mclk(mclk), .rst_n(rst_n), .master_mode(master_mode), .format_i2s(format_i2s),
   .sample_ready(sample_ready), .overrange_event(overrange_event), .overflow_indication(overflow_indication),
   .bit_clk_i(bit_clk_i), .bit_clk_o(bit_clk_o), .bit_clk_oe(bit_clk_oe), .frame_clock_o(frame_clock_o),
   .frame_clock_oe(frame_clock_oe), .serial_data_out(serial_data_out)
);

// ---- audio_rx_model.sv ----
`timescale 1ns/10ps
// ====================
// Receiving processor model
// ====================
module audio_rx_model (
   input  wire logic   bit_clk,
   input  wire logic   frame_clk,
   input  wire logic   sdo,
   input  wire logic   i2s,
   input  wire logic   run,
   output logic        host_bclk,
   output logic        host_fclk,
   output logic        frame_stb,
   output logic [47:0] rx_word,
   output int          pad_errs
);
   int          pos;
   int          p;
   int          hc;
   logic        fq;
   logic [23:0] sh;
   logic [23:0] lw;

   // host 64 ratio
   // Host clocks stand still unless run; frame moves on a falling edge
   initial begin
      host_bclk = 1'b0;
      host_fclk = 1'b0;
      frame_stb = 1'b0;
      rx_word   = 48'h0;
      pad_errs  = 0;
      pos       = 0;
      hc        = 0;
      fq        = 1'b0;
      sh        = 24'h0;
      lw        = 24'h0;
      forever begin
         #6;
         if (run) begin
            host_bclk = ~host_bclk;
            hc        = host_bclk ? hc : hc + 1;
            if (hc == 32) begin
               hc        = 0;
               host_fclk = ~host_fclk;
            end
         end
      end
   end

   // rising edge capture
   // I2S puts the MSB one bit late and marks left with a low frame clock
   always @(posedge bit_clk) begin
      frame_stb = 1'b0;
      pos       = (frame_clk !== fq) ? 0 : pos + 1;
      fq        = frame_clk;
      p         = pos - int'(i2s);
      if (p >= 0 && p < 24)
         sh = {sh[22:0], sdo};
      else if (p >= 24 && p < 32 && sdo !== 1'b0)
         pad_errs++;
      if (p == 23 && (frame_clk ^ i2s))
         lw = sh;
      else if (p == 23) begin
         rx_word   = {lw, sh};
         frame_stb = 1'b1;
      end
   end
endmodule

// ---- audio_out_port_test.sv ----
`timescale 1ns/10ps
// ====================
// Bench top
// ====================
module audio_out_port_test;
   logic        mclk, rst_n, master_mode, format_i2s, sample_valid, overrange_event, run;
   logic [1:0]  speed_mode;
   logic [23:0] sample_left, sample_right;
   logic        sample_ready, overflow_indication, bit_clk_o, bit_clk_oe, frame_stb;
   logic        frame_clock_o, frame_clock_oe, serial_data_out, bclk_w, fclk_w, host_bclk, host_fclk;
   logic [47:0] rx_word;
   logic [47:0] expq[$];
   logic [47:0] rxq[$];
   int          fails, n_compared, pad_errs, cycles, k;

   // Pin resolution: whoever enables drives the wire
   assign bclk_w = bit_clk_oe ? bit_clk_o : host_bclk;
   assign fclk_w = frame_clock_oe ? frame_clock_o : host_fclk;

   audio_out_port #(.FIFO_DEPTH(16), .BCLK_HALF_DIV(2), .OVF_HOLD_FRAMES(4)) DUT (
      .mclk(mclk), .rst_n(rst_n), .master_mode(master_mode), .format_i2s(format_i2s),
      .speed_mode(speed_mode), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_left(sample_left), .sample_right(sample_right), .overrange_event(overrange_event),
      .overflow_indication(overflow_indication), .bit_clk_i(bclk_w), .bit_clk_o(bit_clk_o),
      .bit_clk_oe(bit_clk_oe), .frame_clock_i(fclk_w), .frame_clock_o(frame_clock_o),
      .frame_clock_oe(frame_clock_oe), .serial_data_out(serial_data_out));
   audio_rx_model rx (.bit_clk(bclk_w), .frame_clk(fclk_w), .sdo(serial_data_out), .i2s(format_i2s),
      .run(run), .host_bclk(host_bclk), .host_fclk(host_fclk), .frame_stb(frame_stb),
      .rx_word(rx_word), .pad_errs(pad_errs));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Keep frames that carried data; silent frames are all zero
   always @(posedge frame_stb) if (rx_word !== 48'h0) rxq.push_back(rx_word);

   // Hang guard, well above the roughly 31000 cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         results();
      end
   end

   task automatic results();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input logic [47:0] got, input logic [47:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
   endtask

   task automatic wait_frames(input int n);
      repeat (n) @(posedge frame_stb);
   endtask

   // Offers n frames back to back, each held until taken
   task automatic push(input int n);
      @(negedge mclk);
      for (int i = 0; i < n; i++) begin
         k++;
         sample_left  = {8'ha5, k[15:0]};
         sample_right = {8'h5a, k[15:0]};
         sample_valid = 1'b1;
         expq.push_back({sample_left, sample_right});
         while (sample_ready !== 1'b1) @(negedge mclk);
         @(negedge mclk);
      end
      sample_valid = 1'b0;
   endtask

   task automatic drain_check(input int n);
      check(48'(rxq.size()), 48'(n), "frame count");
      for (int i = 0; i < n && i < rxq.size(); i++) check(rxq[i], expq[i], "frame data");
      rxq.delete();
      expq.delete();
   endtask

   task automatic t_latency(input logic [1:0] mode, input int lat);
      @(negedge mclk);
      speed_mode = mode;
      push(lat - 1);
      wait_frames(4);
      check(48'(rxq.size()), 48'h0, "sent before prefill");
      push(1);
      wait_frames(lat + 3);
      drain_check(lat);
   endtask

   task automatic t_fill();
      int n;
      n = 0;
      @(negedge mclk);
      speed_mode = 2'h0;
      while (sample_ready === 1'b1 && n < 40) begin
         push(1);
         n++;
      end
      check(48'(n >= 17 && n <= 18), 48'h1, "fill depth");
      wait_frames(n + 3);
      drain_check(n);
      check(48'(sample_ready), 48'h1, "empty after drain");
   endtask

   task automatic t_ovf();
      @(negedge mclk);
      overrange_event = 1'b1;
      @(negedge mclk);
      overrange_event = 1'b0;
      @(negedge mclk);
      check(48'(overflow_indication), 48'h1, "flag set");
      wait_frames(2);
      @(negedge mclk);
      overrange_event = 1'b1;
      @(negedge mclk);
      overrange_event = 1'b0;
      wait_frames(2);
      check(48'(overflow_indication), 48'h1, "flag reloaded");
      wait_frames(4);
      repeat (20) @(negedge mclk);
      check(48'(overflow_indication), 48'h0, "flag released");
   endtask

   // Frames in one mode and format; the 12 ns host bit clock runs only in slave mode
   task automatic t_link(input logic mst, input logic fmt);
      @(negedge mclk);
      master_mode = mst;
      format_i2s  = fmt;
      speed_mode  = 2'h2;
      run         = !mst;
      do_reset();
      wait_frames(4);
      rxq.delete();
      push(5);
      wait_frames(9);
      drain_check(5);
      check(48'(pad_errs), 48'h0, "pad bits");
      run = 1'b0;
   endtask

   initial begin
      master_mode     = 1'b1;
      format_i2s      = 1'b0;
      speed_mode      = 2'h0;
      sample_valid    = 1'b0;
      sample_left     = 24'h0;
      sample_right    = 24'h0;
      overrange_event = 1'b0;
      run             = 1'b0;
      fails           = 0;
      n_compared      = 0;
      cycles          = 0;
      k               = 0;
      do_reset();
      t_latency(2'h0, 12);
      t_latency(2'h1, 9);
      t_latency(2'h2, 5);
      t_latency(2'h3, 12);
      t_fill();
      t_ovf();
      t_link(1'b0, 1'b1);
      t_link(1'b0, 1'b0);
      t_link(1'b1, 1'b1);
      results();
   end
endmodule
